// ===== inc/csf_pkg.sv
// csf_pkg: constants, register offsets, bit positions and op codes of the status flag block.
// Assumes a single 50 MHz core clock and an 8-bit data path.
package csf_pkg;
  // widths and sizes
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 8;
  localparam int GPR_DEPTH = 64;
  localparam int GPR_AW    = 6;
  localparam int IRQ_W     = 3;

  // bank-0 offsets
  localparam logic [ADDR_W-1:0] OFS_INDIRECT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_POINTER  = 8'h04;
  localparam logic [ADDR_W-1:0] GPR_BASE     = 8'h40;
  localparam logic [ADDR_W-1:0] GPR_LAST     = 8'h7F;
  // event registers, above the bank
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h80;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h81;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h82;
  // indirect pointer only reaches the bank
  localparam logic [ADDR_W-1:0] PTR_MASK     = 8'h7F;

  // arith_and_power_flags bit positions
  localparam int BIT_IND_PAGE = 7;
  localparam int BIT_BANK_HI  = 6;
  localparam int BIT_BANK_LO  = 5;
  localparam int BIT_WDT_N    = 4;
  localparam int BIT_SLEEP_N  = 3;
  localparam int BIT_ZERO     = 2;
  localparam int BIT_NIB      = 1;
  localparam int BIT_CARRY    = 0;

  // event bits
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_SLEEP   = 1;
  localparam int IRQ_WDCLR   = 2;

  // reset values
  localparam logic [DATA_W-1:0] FLAGS_POR_RST = 8'h18;
  localparam logic [DATA_W-1:0] PTR_POR_RST   = 8'h00;
  localparam logic [DATA_W-1:0] DATA_RST      = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_RST       = 3'h0;

  // execution unit operations
  typedef enum logic [2:0] {
    CSF_OP_NONE,
    CSF_OP_ADD,
    CSF_OP_SUB,
    CSF_OP_ROR,
    CSF_OP_ROL,
    CSF_OP_LOGIC
  } csf_op_t;
endpackage

// ===== core/csf_gpr_ram.sv
// csf_gpr_ram: general purpose register file, one write port, one registered read port.
// Assumes the caller resolves addresses to a zero-based index.
`timescale 1ns/1ns
module csf_gpr_ram #(
  parameter int DW    = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // clock
  input  wire logic          sys_clk,
  input  wire logic          clk_en,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data_reg
);
  logic [DW-1:0] mem [DEPTH];

  // no reset on the array: contents are unknown after power-up anyway
  always_ff @(posedge sys_clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en && rd_en) begin
      rd_data_reg <= mem[rd_addr];
    end
  end
endmodule

// ===== core/csf_core.sv
// csf_core: arithmetic and power status flags, bank-0 decode, indirect access, event interrupt.
// Assumes the execution unit presents one operation per cycle and the bus master never
// strobes while clk_en is low.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module csf_core #(
  parameter int GPR_DEPTH = csf_pkg::GPR_DEPTH
) (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  input  wire logic                         clk_en,
  input  wire logic                         por_reset,
  // execution unit
  input  wire logic                         alu_valid,
  input  wire csf_pkg::csf_op_t             alu_op,
  input  wire logic [csf_pkg::DATA_W-1:0]   alu_a,
  input  wire logic [csf_pkg::DATA_W-1:0]   alu_w,
  input  wire logic [csf_pkg::DATA_W-1:0]   alu_logic_result,
  input  wire logic                         alu_dest_file,
  input  wire logic [csf_pkg::ADDR_W-1:0]   alu_dest_addr,
  output logic      [csf_pkg::DATA_W-1:0]   alu_result_reg,
  // watchdog and power events
  input  wire logic                         watchdog_clear_op,
  input  wire logic                         sleep_op,
  input  wire logic                         wdt_timeout,
  // register bus
  input  wire logic [csf_pkg::ADDR_W-1:0]   bus_addr,
  input  wire logic [csf_pkg::DATA_W-1:0]   bus_wdata,
  input  wire logic                         bus_wr,
  input  wire logic                         bus_rd,
  output logic      [csf_pkg::DATA_W-1:0]   bus_rdata,
  // status
  output logic      [csf_pkg::DATA_W-1:0]   arith_and_power_flags,
  output logic                              irq
);
  import csf_pkg::*;

  logic [DATA_W-1:0] flags_reg;
  logic [DATA_W-1:0] flags_next;
  logic [DATA_W-1:0] indirect_pointer_reg;
  logic [DATA_W-1:0] rd_hold_reg;
  logic              rd_gpr_reg;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_stat_next;
  logic [IRQ_W-1:0]  irq_en_reg;
  logic [DATA_W-1:0] ram_q;

  // address resolution
  wire logic [ADDR_W-1:0] ptr_addr     = indirect_pointer_reg & PTR_MASK;
  wire logic [ADDR_W-1:0] bus_eff      = (bus_addr == OFS_INDIRECT) ? ptr_addr : bus_addr;
  wire logic [ADDR_W-1:0] alu_eff      = (alu_dest_addr == OFS_INDIRECT) ? ptr_addr
                                         : alu_dest_addr;
  wire logic              bus_hit_flg  = (bus_eff == OFS_FLAGS);
  wire logic              bus_hit_ptr  = (bus_eff == OFS_POINTER);
  wire logic              bus_hit_gpr  = (bus_eff >= GPR_BASE) && (bus_eff <= GPR_LAST);
  wire logic              bus_hit_ist  = (bus_eff == OFS_IRQ_STAT);
  wire logic              bus_hit_ien  = (bus_eff == OFS_IRQ_EN);
  wire logic              bus_hit_icl  = (bus_eff == OFS_IRQ_CLR);
  wire logic              bus_unimpl   = !(bus_hit_flg || bus_hit_ptr || bus_hit_gpr
                                           || bus_hit_ist || bus_hit_ien);
  wire logic              alu_wr       = alu_valid && alu_dest_file;
  wire logic              alu_hit_flg  = alu_wr && (alu_eff == OFS_FLAGS);
  wire logic              alu_hit_ptr  = alu_wr && (alu_eff == OFS_POINTER);
  wire logic              alu_hit_gpr  = alu_wr && (alu_eff >= GPR_BASE)
                                         && (alu_eff <= GPR_LAST);
  wire logic              bus_wr_flg   = bus_wr && bus_hit_flg;
  wire logic              bus_wr_ptr   = bus_wr && bus_hit_ptr;

  // arithmetic: subtraction is an add of the inverted operand plus one
  wire logic              op_add       = alu_valid && (alu_op == CSF_OP_ADD);
  wire logic              op_sub       = alu_valid && (alu_op == CSF_OP_SUB);
  wire logic              op_ror       = alu_valid && (alu_op == CSF_OP_ROR);
  wire logic              op_rol       = alu_valid && (alu_op == CSF_OP_ROL);
  wire logic              op_logic     = alu_valid && (alu_op == CSF_OP_LOGIC);
  wire logic              op_arith     = op_add || op_sub;
  wire logic [DATA_W-1:0] opnd_b       = op_sub ? ~alu_w : alu_w;
  wire logic [4:0]        nib_sum      = {1'b0, alu_a[3:0]} + {1'b0, opnd_b[3:0]}
                                         + {4'h0, op_sub};
  wire logic [8:0]        full_sum     = {1'b0, alu_a} + {1'b0, opnd_b}
                                         + {8'h00, op_sub};
  wire logic              cur_carry    = flags_reg[BIT_CARRY];
  wire logic [DATA_W-1:0] alu_res      = op_arith ? full_sum[7:0]
                                         : op_ror ? {cur_carry, alu_a[7:1]}
                                         : op_rol ? {alu_a[6:0], cur_carry}
                                         : alu_logic_result;
  wire logic              upd_zero     = op_arith || op_logic;
  wire logic              upd_carry    = op_arith || op_ror || op_rol;
  wire logic              new_zero     = (alu_res == DATA_RST);
  // carry out doubles as inverted borrow in subtraction
  wire logic              new_nib      = nib_sum[4];
  wire logic              new_carry    = op_arith ? full_sum[8]
                                         : op_ror ? alu_a[0]
                                         : alu_a[7];

  // register bus write masks
  wire logic [IRQ_W-1:0]  irq_clr_mask = (bus_wr && bus_hit_icl) ? bus_wdata[IRQ_W-1:0]
                                         : IRQ_RST;
  wire logic [IRQ_W-1:0]  irq_events   = {watchdog_clear_op, sleep_op, wdt_timeout};

  // flag register next value; later steps take priority over earlier ones
  always_comb begin
    flags_next = flags_reg;
    // bank bits are plain storage; software is expected to keep them clear
    if (bus_wr_flg) begin
      flags_next[BIT_IND_PAGE:BIT_BANK_LO] = bus_wdata[BIT_IND_PAGE:BIT_BANK_LO];
      flags_next[BIT_ZERO:BIT_CARRY]       = bus_wdata[BIT_ZERO:BIT_CARRY];
    end
    // an op that computes any result flag drops the written value of all three
    if (alu_hit_flg) begin
      flags_next[BIT_IND_PAGE:BIT_BANK_LO] = alu_res[BIT_IND_PAGE:BIT_BANK_LO];
      if (!(upd_zero || upd_carry)) begin
        flags_next[BIT_ZERO:BIT_CARRY] = alu_res[BIT_ZERO:BIT_CARRY];
      end
    end
    // computed flags override any written value
    if (upd_zero) begin
      flags_next[BIT_ZERO] = new_zero;
    end
    if (op_arith) begin
      flags_next[BIT_NIB] = new_nib;
    end
    if (upd_carry) begin
      flags_next[BIT_CARRY] = new_carry;
    end
    // power flags are never writable; time-out wins over a same-cycle clear
    if (sleep_op) begin
      flags_next[BIT_WDT_N]   = 1'b1;
      flags_next[BIT_SLEEP_N] = 1'b0;
    end
    if (watchdog_clear_op) begin
      flags_next[BIT_WDT_N]   = 1'b1;
      flags_next[BIT_SLEEP_N] = 1'b1;
    end
    if (wdt_timeout) begin
      flags_next[BIT_WDT_N] = 1'b0;
    end
  end

  // set wins over clear
  assign irq_stat_next = (irq_stat_reg & ~irq_clr_mask) | irq_events;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flags_reg[BIT_IND_PAGE:BIT_BANK_LO] <= FLAGS_POR_RST[BIT_IND_PAGE:BIT_BANK_LO];
      if (por_reset) begin
        flags_reg[BIT_WDT_N:BIT_CARRY] <= FLAGS_POR_RST[BIT_WDT_N:BIT_CARRY];
      end
    end else if (clk_en) begin
      flags_reg <= flags_next;
    end
  end

  // pointer keeps its value across non power-on resets
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      if (por_reset) begin
        indirect_pointer_reg <= PTR_POR_RST;
      end
    end else if (clk_en) begin
      if (alu_hit_ptr) begin
        indirect_pointer_reg <= alu_res;
      end else if (bus_wr_ptr) begin
        indirect_pointer_reg <= bus_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      alu_result_reg <= DATA_RST;
    end else if (clk_en && alu_valid) begin
      alu_result_reg <= alu_res;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_stat_reg <= IRQ_RST;
      irq_en_reg   <= IRQ_RST;
    end else if (clk_en) begin
      irq_stat_reg <= irq_stat_next;
      if (bus_wr && bus_hit_ien) begin
        irq_en_reg <= bus_wdata[IRQ_W-1:0];
      end
    end
  end

  // read path: registers captured here, general RAM answers from its own output register
  wire logic [DATA_W-1:0] rd_mux = bus_hit_flg ? flags_reg
                                   : bus_hit_ptr ? indirect_pointer_reg
                                   : bus_hit_ist ? {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg}
                                   : bus_hit_ien ? {{(DATA_W-IRQ_W){1'b0}}, irq_en_reg}
                                   : DATA_RST;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_hold_reg <= DATA_RST;
      rd_gpr_reg  <= 1'b0;
    end else if (clk_en) begin
      rd_hold_reg <= bus_rd ? rd_mux : DATA_RST;
      rd_gpr_reg  <= bus_rd && bus_hit_gpr;
    end
  end

  assign bus_rdata             = rd_gpr_reg ? ram_q : rd_hold_reg;
  assign arith_and_power_flags = flags_reg;
  assign irq                   = |(irq_stat_reg & irq_en_reg);

  // execution unit write-back beats a colliding bus write to RAM
  wire logic              ram_we    = alu_hit_gpr || (bus_wr && bus_hit_gpr);
  wire logic [GPR_AW-1:0] ram_waddr = alu_hit_gpr ? alu_eff[GPR_AW-1:0] : bus_eff[GPR_AW-1:0];
  wire logic [DATA_W-1:0] ram_wdata = alu_hit_gpr ? alu_res : bus_wdata;

  csf_gpr_ram #(
    .DW    (DATA_W),
    .DEPTH (GPR_DEPTH),
    .AW    (GPR_AW)
  ) u_gpr (
    .sys_clk     (sys_clk),
    .clk_en      (clk_en),
    .wr_en       (ram_we),
    .wr_addr     (ram_waddr),
    .wr_data     (ram_wdata),
    .rd_en       (bus_rd && bus_hit_gpr),
    .rd_addr     (bus_eff[GPR_AW-1:0]),
    .rd_data_reg (ram_q)
  );

  // checking helpers
  logic [DATA_W-1:0] chk_a_reg;
  logic [DATA_W-1:0] chk_w_reg;
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      chk_a_reg <= alu_a;
      chk_w_reg <= alu_w;
    end
  end
  wire logic [4:0] chk_nib = {1'b0, chk_a_reg[3:0]} + {1'b0, chk_w_reg[3:0]};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_timeout_clears: assert property (
    clk_en && wdt_timeout |=> !flags_reg[BIT_WDT_N])
    else $error("expiry flag not cleared by time-out");
  a_sleep_flags: assert property (
    clk_en && sleep_op && !watchdog_clear_op && !wdt_timeout
    |=> flags_reg[BIT_WDT_N] && !flags_reg[BIT_SLEEP_N])
    else $error("sleep did not set power flags as expected");
  a_zero_follows: assert property (
    clk_en && alu_valid && (alu_op inside {CSF_OP_ADD, CSF_OP_SUB, CSF_OP_LOGIC})
    |=> flags_reg[BIT_ZERO] == (alu_result_reg == DATA_RST))
    else $error("zero flag disagrees with result");
  a_nibble_add: assert property (
    clk_en && op_add |=> flags_reg[BIT_NIB] == chk_nib[4])
    else $error("nibble flag wrong after add");
  a_carry_add: assert property (
    clk_en && op_add |=> flags_reg[BIT_CARRY] == ({1'b0, chk_a_reg} + {1'b0, chk_w_reg} > 9'h0FF))
    else $error("carry flag wrong after add");
  a_borrow_sub: assert property (
    clk_en && op_sub |=> flags_reg[BIT_CARRY] == (chk_a_reg >= chk_w_reg)
                         && flags_reg[BIT_NIB] == (chk_a_reg[3:0] >= chk_w_reg[3:0]))
    else $error("borrow polarity wrong after subtract");
  a_sub_result: assert property (
    clk_en && op_sub |=> alu_result_reg == chk_a_reg - chk_w_reg)
    else $error("subtract result wrong");
  a_rotate_right: assert property (
    clk_en && op_ror |=> flags_reg[BIT_CARRY] == chk_a_reg[0]
                         && alu_result_reg[6:0] == chk_a_reg[7:1])
    else $error("rotate right carry or result wrong");
  a_por_values: assert property (
    $rose(rstn) && $past(por_reset) |-> flags_reg[BIT_IND_PAGE:BIT_SLEEP_N] == 5'h03)
    else $error("power-on flag values wrong");
  a_unimpl_zero: assert property (
    clk_en && bus_rd && bus_unimpl |=> bus_rdata == DATA_RST)
    else $error("unimplemented location read nonzero");
  a_indirect_ptr: assert property (
    clk_en && bus_rd && bus_addr == OFS_INDIRECT && ptr_addr == OFS_POINTER && !alu_hit_ptr
    |=> bus_rdata == $past(indirect_pointer_reg))
    else $error("indirect read not redirected");
  a_status_dest: assert property (
    clk_en && op_add && alu_hit_flg |=> flags_reg[BIT_ZERO] == (alu_result_reg == DATA_RST))
    else $error("written value overrode computed zero flag");

  // power flags ignore bus writes; only the three events and a power-on reset move them
  a_wdclr_flags: assert property (
    clk_en && watchdog_clear_op && !wdt_timeout
    |=> flags_reg[BIT_WDT_N] && flags_reg[BIT_SLEEP_N])
    else $error("watchdog clear did not set power flags");
  a_power_ro: assert property (
    clk_en && bus_wr_flg && !sleep_op && !watchdog_clear_op && !wdt_timeout
    |=> flags_reg[BIT_WDT_N:BIT_SLEEP_N] == $past(flags_reg[BIT_WDT_N:BIT_SLEEP_N]))
    else $error("bus write moved a power flag");
  a_bank_reset: assert property (
    $rose(rstn) |-> flags_reg[BIT_IND_PAGE:BIT_BANK_LO] == 3'h0)
    else $error("bank bits not cleared by reset");

  // rotate left mirrors the right-hand check one bit over
  a_rotate_left: assert property (
    clk_en && op_rol |=> flags_reg[BIT_CARRY] == chk_a_reg[7]
                         && alu_result_reg[7:1] == chk_a_reg[6:0])
    else $error("rotate left carry or result wrong");
  a_dest_keep: assert property (
    clk_en && op_logic && alu_hit_flg && !bus_wr_flg
    |=> flags_reg[BIT_NIB:BIT_CARRY] == $past(flags_reg[BIT_NIB:BIT_CARRY]))
    else $error("write to flag register overrode kept carry flags");

  // read data stand one cycle only, so a late sample sees zero
  a_ptr_read: assert property (
    clk_en && bus_rd && bus_hit_ptr |=> bus_rdata == $past(indirect_pointer_reg))
    else $error("pointer read wrong");
  a_flags_read: assert property (
    clk_en && bus_rd && bus_hit_flg |=> bus_rdata == $past(flags_reg))
    else $error("flag register read wrong");
  a_rdata_idle: assert property (
    clk_en && !bus_rd |=> bus_rdata == DATA_RST)
    else $error("read data stood past their cycle");

  a_timeout_latched: assert property (
    clk_en && wdt_timeout |=> irq_stat_reg[IRQ_TIMEOUT])
    else $error("time-out event not latched");
  // a low enable must hold every register, not just skip updates
  a_freeze_holds_state: assert property (
    !clk_en |=> flags_reg == $past(flags_reg)
                && indirect_pointer_reg == $past(indirect_pointer_reg)
                && alu_result_reg == $past(alu_result_reg))
    else $error("state moved while clock enable low");

  c_add_carry: cover property (clk_en && op_add && full_sum[8]);
  c_sleep_timeout: cover property (clk_en && sleep_op ##[1:20] clk_en && wdt_timeout);
  c_indirect_rd: cover property (clk_en && bus_rd && bus_addr == OFS_INDIRECT && bus_hit_gpr);
  c_irq_raised: cover property ($rose(irq));
  c_dest_flags: cover property (clk_en && alu_hit_flg && op_logic);
endmodule

// ===== sim/csf_exec_model.sv
// csf_exec_model: stand-in for the execution unit and watchdog that feed csf_core.
// Assumes the bench calls its tasks; all changes follow a rising edge.
`timescale 1ns/1ns
module csf_exec_model (
  // clock
  input  wire logic                       sys_clk,
  // operation
  output logic                            alu_valid,
  output csf_pkg::csf_op_t                alu_op,
  output logic [csf_pkg::DATA_W-1:0]      alu_a,
  output logic [csf_pkg::DATA_W-1:0]      alu_w,
  output logic [csf_pkg::DATA_W-1:0]      alu_logic_result,
  output logic                            alu_dest_file,
  output logic [csf_pkg::ADDR_W-1:0]      alu_dest_addr,
  // events
  output logic                            watchdog_clear_op,
  output logic                            sleep_op,
  output logic                            wdt_timeout
);
  import csf_pkg::*;
  initial begin
    {alu_valid, alu_dest_file, watchdog_clear_op, sleep_op, wdt_timeout} = 5'h00;
    alu_op = CSF_OP_NONE;
    {alu_a, alu_w, alu_logic_result, alu_dest_addr} = 32'h0;
  end
  task automatic issue(input csf_op_t o, input logic [7:0] x, input logic [7:0] y,
                       input logic [7:0] l, input logic f, input logic [7:0] d);
    @(posedge sys_clk);
    alu_valid <= 1'b1;
    alu_op <= o;
    alu_a <= x;
    alu_w <= y;
    alu_logic_result <= l;
    alu_dest_file <= f;
    alu_dest_addr <= d;
    @(posedge sys_clk);
    alu_valid <= 1'b0;
    // stale operands inverted so a late sample cannot match by luck
    alu_a <= ~x;
    alu_w <= ~y;
    alu_logic_result <= ~l;
    alu_dest_file <= 1'b0;
  endtask
  // k: 0 watchdog clear, 1 sleep, 2 time-out
  task automatic ev(input int k);
    @(posedge sys_clk);
    watchdog_clear_op <= (k == 0);
    sleep_op <= (k == 1);
    wdt_timeout <= (k == 2);
    @(posedge sys_clk);
    {watchdog_clear_op, sleep_op, wdt_timeout} <= 3'h0;
  endtask
endmodule

// ===== sim/tb.sv
// tb: self-checking bench for csf_core driven through the execution unit model.
// Assumes one 50 MHz clock; clk_en stays high except in the freeze scenario.
`timescale 1ns/1ns
module tb;
  import csf_pkg::*;
  logic       sys_clk, rstn, por_reset, bus_wr, bus_rd, irq, v, df, wc, sl, to, ce;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, flags, res, a, w, lr, da;
  csf_op_t    op;
  int         n_mismatch = 0;
  int         compares = 0;

  csf_core csf_core_i (.sys_clk(sys_clk), .rstn(rstn), .clk_en(ce),
    .por_reset(por_reset), .alu_valid(v), .alu_op(op), .alu_a(a), .alu_w(w),
    .alu_logic_result(lr), .alu_dest_file(df), .alu_dest_addr(da),
    .alu_result_reg(res), .watchdog_clear_op(wc), .sleep_op(sl), .wdt_timeout(to),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .arith_and_power_flags(flags), .irq(irq));
  csf_exec_model csf_exec_model_i (.sys_clk(sys_clk), .alu_valid(v), .alu_op(op),
    .alu_a(a), .alu_w(w), .alu_logic_result(lr), .alu_dest_file(df),
    .alu_dest_addr(da), .watchdog_clear_op(wc), .sleep_op(sl), .wdt_timeout(to));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= ad;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] ad, input logic [7:0] e);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= ad;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 chk(nm, bus_rdata, e);
  endtask
  task automatic alu(input csf_op_t o, input logic [7:0] x, input logic [7:0] l);
    csf_exec_model_i.issue(o, x, 8'h00, l, 1'b0, 8'h00);
    #1;
  endtask
  task automatic do_reset(input logic p);
    @(posedge sys_clk);
    rstn <= 1'b0;
    por_reset <= p;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic t_map;
    logic [7:0] gap [5] = '{8'h01, 8'h02, 8'h05, 8'h1F, 8'h3F};
    foreach (gap[i]) rdc("gap", gap[i], 8'h00);
    wr(8'h10, 8'hFF);
    rdc("gap wr", 8'h10, 8'h00);
    wr(GPR_BASE, 8'hA5);
    wr(GPR_LAST, 8'h5A);
    rdc("ram lo", GPR_BASE, 8'hA5);
    rdc("ram hi", GPR_LAST, 8'h5A);
    wr(OFS_POINTER, 8'h41);
    rdc("ptr", OFS_POINTER, 8'h41);
    wr(OFS_INDIRECT, 8'hC3);
    rdc("ind ram", 8'h41, 8'hC3);
    rdc("ind rd", OFS_INDIRECT, 8'hC3);
    wr(OFS_POINTER, 8'h00);
    wr(OFS_INDIRECT, 8'h77);
    rdc("ind self", OFS_INDIRECT, 8'h00);
    csf_exec_model_i.issue(CSF_OP_LOGIC, 8'h00, 8'h00, 8'h9C, 1'b1, 8'h50);
    rdc("alu ram", 8'h50, 8'h9C);
    csf_exec_model_i.issue(CSF_OP_LOGIC, 8'h00, 8'h00, 8'h04, 1'b1, OFS_POINTER);
    rdc("alu ptr", OFS_INDIRECT, 8'h04);
  endtask

  task automatic t_arith;
    logic [7:0] av [5] = '{8'h0F, 8'hFF, 8'h80, 8'h03, 8'h12};
    logic [7:0] wv [5] = '{8'h01, 8'h01, 8'h80, 8'h05, 8'h04};
    logic [8:0] s;
    logic [4:0] n;
    for (int i = 0; i < 5; i++) begin
      s = {1'b0, av[i]} + {1'b0, wv[i]};
      n = {1'b0, av[i][3:0]} + {1'b0, wv[i][3:0]};
      csf_exec_model_i.issue(CSF_OP_ADD, av[i], wv[i], 8'h00, 1'b0, 8'h00);
      #1 chk("add res", res, s[7:0]);
      chk("add flg", {5'h00, flags[2:0]}, {5'h00, s[7:0] == 8'h00, n[4], s[8]});
      // borrow taken as the carry of a plus the two's complement of w
      s = {1'b0, av[i]} + {1'b0, ~wv[i]} + 9'h001;
      n = {1'b0, av[i][3:0]} + {1'b0, ~wv[i][3:0]} + 5'h01;
      csf_exec_model_i.issue(CSF_OP_SUB, av[i], wv[i], 8'h00, 1'b0, 8'h00);
      #1 chk("sub res", res, s[7:0]);
      chk("sub flg", {5'h00, flags[2:0]}, {5'h00, s[7:0] == 8'h00, n[4], s[8]});
      chk("sub nb", {7'h00, flags[0]}, {7'h00, av[i] >= wv[i]});
    end
  endtask

  task automatic t_rot;
    alu(CSF_OP_ADD, 8'h00, 8'h00);
    chk("zero", {5'h00, flags[2:0]}, 8'h04);
    alu(CSF_OP_ROR, 8'h81, 8'h00);
    chk("ror res", res, 8'h40);
    chk("ror flg", {5'h00, flags[2:0]}, 8'h05);
    alu(CSF_OP_ROL, 8'h01, 8'h00);
    chk("rol res", res, 8'h03);
    chk("rol flg", {5'h00, flags[2:0]}, 8'h04);
    alu(CSF_OP_ROL, 8'h80, 8'h00);
    chk("rol msb", {5'h00, flags[2:0]}, 8'h05);
    alu(CSF_OP_LOGIC, 8'h00, 8'h5A);
    chk("log nz", {5'h00, flags[2:0]}, 8'h01);
    alu(CSF_OP_LOGIC, 8'h00, 8'h00);
    chk("log z", {5'h00, flags[2:0]}, 8'h05);
  endtask

  task automatic t_pwr_irq;
    wr(OFS_IRQ_EN, 8'h07);
    csf_exec_model_i.ev(1);
    #1 chk("pwr slp", {6'h00, flags[4:3]}, 8'h02);
    chk("irq slp", {7'h00, irq}, 8'h01);
    rdc("irq st", OFS_IRQ_STAT, 8'h02);
    wr(OFS_IRQ_CLR, 8'h02);
    #1 chk("irq clr", {7'h00, irq}, 8'h00);
    wr(OFS_IRQ_EN, 8'h00);
    csf_exec_model_i.ev(2);
    #1 chk("pwr tmo", {6'h00, flags[4:3]}, 8'h00);
    chk("irq mask", {7'h00, irq}, 8'h00);
    wr(OFS_IRQ_EN, 8'h01);
    #1 chk("irq unmask", {7'h00, irq}, 8'h01);
    wr(OFS_IRQ_STAT, 8'hFF);
    rdc("irq st ro", OFS_IRQ_STAT, 8'h01);
    rdc("irq clr rd", OFS_IRQ_CLR, 8'h00);
    csf_exec_model_i.ev(0);
    #1 chk("pwr wclr", {6'h00, flags[4:3]}, 8'h03);
    rdc("irq st2", OFS_IRQ_STAT, 8'h05);
    wr(OFS_IRQ_CLR, 8'h07);
    #1 chk("irq off", {7'h00, irq}, 8'h00);
  endtask

  // ops and events while frozen must leave every register alone
  task automatic t_freeze;
    @(posedge sys_clk);
    ce <= 1'b0;
    csf_exec_model_i.issue(CSF_OP_ADD, 8'h11, 8'h22, 8'h00, 1'b0, 8'h00);
    csf_exec_model_i.ev(2);
    #1 chk("frz flg", flags, 8'h1D);
    chk("frz res", res, 8'h00);
    chk("frz irq", {7'h00, irq}, 8'h00);
    @(posedge sys_clk);
    ce <= 1'b1;
  endtask

  task automatic t_dest_reset;
    csf_exec_model_i.issue(CSF_OP_ADD, 8'h1F, 8'h01, 8'h00, 1'b1, OFS_FLAGS);
    #1 chk("dest flg", flags, 8'h3A);
    csf_exec_model_i.issue(CSF_OP_LOGIC, 8'h00, 8'h00, 8'h00, 1'b1, OFS_FLAGS);
    #1 chk("dest log", flags, 8'h1E);
    wr(OFS_FLAGS, 8'h00);
    #1 chk("flg wr", flags, 8'h18);
    rdc("flg rd", OFS_FLAGS, 8'h18);
    csf_exec_model_i.ev(1);
    // bank bits set here only to see reset clear them
    wr(OFS_FLAGS, 8'hE5);
    wr(OFS_POINTER, 8'h45);
    #1 chk("flg pre", flags, 8'hF5);
    do_reset(1'b0);
    chk("warm flg", flags, 8'h15);
    rdc("warm ptr", OFS_POINTER, 8'h45);
    do_reset(1'b1);
    chk("por flg", flags, FLAGS_POR_RST);
    rdc("por en", OFS_IRQ_EN, 8'h00);
    rdc("por ptr", OFS_POINTER, PTR_POR_RST);
  endtask

  initial begin
    rstn = 1'b0;
    por_reset = 1'b1;
    {bus_wr, bus_rd, bus_addr, bus_wdata} = 18'h0;
    ce = 1'b1;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    #1 chk("por init", flags, FLAGS_POR_RST);
    t_map;
    t_arith;
    t_rot;
    t_pwr_irq;
    t_freeze;
    t_dest_reset;
    wrap_up;
  end

  // whole run is well under 1000 cycles
  initial begin
    #100000;
    n_mismatch++;
    wrap_up;
  end
endmodule
